// *** mcbt_exec.sv ***
// Executor for external data moves, code table loads, byte/nibble exchange
// and the single-bit processor, for an 8-bit controller core.
// Assumes op_valid is only raised while op_ready is high, and that both
// memory ports answer on the same clock with a one-cycle ack pulse.
//
// Overview of operation
// RQ1: External data uses pointer register or data pointer
// RQ2: External data always moves via the accumulator
// RQ3: Constant load reads code at pointer plus accumulator
// RQ4: Counter constant load uses next-instruction address base
// RQ5: Table lookups only read program memory
// RQ6: 128 RAM bits plus register-space bits addressable
// RQ7: Bit addresses 00h-7Fh RAM, 80h-FFh registers
// RQ8: Each port line written as its own bit
// RQ9: Bit operand is a direct address in instruction
// RQ10: Move, set, clear, complement, AND, OR on bits
// RQ11: Carry is bit accumulator and directly addressable
// RQ12: Carry operand forms have their own opcodes
// RQ13: No exclusive-OR bit operation exists
// RQ14: Set-forms branch on one, clear-forms on zero
// RQ15: Test-and-clear branches and clears in one step
// RQ16: Every status word bit is bit-addressable
// RQ17: Byte exchange swaps accumulator and addressed byte
// RQ18: Nibble exchange swaps only low nibbles
// RQ19: Table address is unsigned 16-bit sum
`timescale 1ns/100ps
module mcbt_exec (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_byte1,
  input wire logic [7:0] op_byte2,
  input wire logic [15:0] pc_next,
  output logic op_ready,
  output logic op_done,
  output logic illegal_op,
  output logic branch_taken,
  output logic [15:0] branch_target,
  output logic xmem_req,
  output logic xmem_we,
  output logic [15:0] xmem_addr,
  output logic [7:0] xmem_wdata,
  input wire logic xmem_ack,
  input wire logic [7:0] xmem_rdata,
  output logic cmem_req,
  output logic [15:0] cmem_addr,
  input wire logic cmem_ack,
  input wire logic [7:0] cmem_rdata,
  input wire logic [31:0] port_pin_in,
  output logic [31:0] port_latch_out,
  output logic [7:0] acc_out,
  output logic [7:0] status_word_out,
  output logic [15:0] data_pointer16_out
);

  mcbt_pkg::mcbt_regs_t r;
  mcbt_pkg::mcbt_regs_t next_r;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Address of R0 or R1 in the bank chosen by the status word
  function automatic logic [7:0] ptr_addr(input logic [7:0] sw, input logic sel);
    ptr_addr = {3'b000, sw[mcbt_pkg::BANK_LO_POS+1 -: 2], 2'b00, sel};
  endfunction : ptr_addr

  // Status word with parity bit live from the accumulator
  function automatic logic [7:0] stat_view(input mcbt_pkg::mcbt_regs_t s);
    stat_view = {s.stat[7:1], ^s.acc};
  endfunction : stat_view

  // Byte read; ports return pins unless the latch is asked for
  function automatic logic [7:0] rd_byte(input mcbt_pkg::mcbt_regs_t s,
                                         input logic [7:0] a, input logic latch);
    rd_byte = 8'h00;
    if (!a[7]) begin
      rd_byte = s.iram[a[6:0]];
    end else begin
      case (a)
        mcbt_pkg::REG_PORT0: rd_byte = latch ? s.port[0] : s.pin_s2[7:0];
        mcbt_pkg::REG_PORT1: rd_byte = latch ? s.port[1] : s.pin_s2[15:8];
        mcbt_pkg::REG_PORT2: rd_byte = latch ? s.port[2] : s.pin_s2[23:16];
        mcbt_pkg::REG_PORT3: rd_byte = latch ? s.port[3] : s.pin_s2[31:24];
        mcbt_pkg::REG_DP_LO: rd_byte = s.dp16[7:0];
        mcbt_pkg::REG_DP_HI: rd_byte = s.dp16[15:8];
        mcbt_pkg::REG_STATUS: rd_byte = stat_view(s);
        mcbt_pkg::REG_ACC: rd_byte = s.acc;
        mcbt_pkg::REG_BREG: rd_byte = s.breg;
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction : rd_byte

  // Byte write; unimplemented register addresses drop the write
  function automatic mcbt_pkg::mcbt_regs_t wr_byte(input mcbt_pkg::mcbt_regs_t s,
                                                   input logic [7:0] a,
                                                   input logic [7:0] v);
    wr_byte = s;
    if (!a[7]) begin
      wr_byte.iram[a[6:0]] = v;
    end else begin
      case (a)
        mcbt_pkg::REG_PORT0: wr_byte.port[0] = v;
        mcbt_pkg::REG_PORT1: wr_byte.port[1] = v;
        mcbt_pkg::REG_PORT2: wr_byte.port[2] = v;
        mcbt_pkg::REG_PORT3: wr_byte.port[3] = v;
        mcbt_pkg::REG_DP_LO: wr_byte.dp16[7:0] = v;
        mcbt_pkg::REG_DP_HI: wr_byte.dp16[15:8] = v;
        mcbt_pkg::REG_STATUS: wr_byte.stat = v;
        mcbt_pkg::REG_ACC: wr_byte.acc = v;
        mcbt_pkg::REG_BREG: wr_byte.breg = v;
        default: wr_byte = s;
      endcase
    end
  endfunction : wr_byte

  // Relative branch target from the next-instruction address
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
    rel_target = pc + {{8{rel[7]}}, rel};
  endfunction : rel_target

  // ==========================================================================
  // Bit operand decode
  // ==========================================================================
  // Half flag unused: the byte address already carries it in bit 7
  mcbt_bit_decode u_bit_decode (
    .bit_addr(op_byte1), // [RQ9]
    .byte_addr(bit_byte),
    .bit_pos(bit_pos),
    .in_reg_space()
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic [7:0] pin_byte;
    logic [7:0] latch_byte;
    logic bit_val;
    logic bit_latch;
    logic carry;
    logic [7:0] mem_val;
    logic [7:0] reg_a;
    pin_byte = 8'h00;
    latch_byte = 8'h00;
    bit_val = 1'b0;
    bit_latch = 1'b0;
    carry = 1'b0;
    mem_val = 8'h00;
    reg_a = 8'h00;
    next_r = r;
    next_r.pin_s1 = port_pin_in;
    next_r.pin_s2 = r.pin_s1;
    next_r.op_done = 1'b0;
    next_r.branch_taken = 1'b0;
    next_r.illegal_op = 1'b0;
    case (r.st)
      mcbt_pkg::MCBT_IDLE: begin
        if (op_valid) begin
          // Bits in both halves share one read path [RQ6] [RQ7] [RQ16]
          pin_byte = rd_byte(r, bit_byte, 1'b0);
          latch_byte = rd_byte(r, bit_byte, 1'b1);
          bit_val = pin_byte[bit_pos];
          bit_latch = latch_byte[bit_pos];
          carry = r.stat[mcbt_pkg::CARRY_POS]; // [RQ11]
          next_r.op_done = 1'b1;
          next_r.branch_target = rel_target(pc_next, op_byte2);
          case (op_code)
            mcbt_pkg::OP_XMEM_RD_DP, mcbt_pkg::OP_XMEM_WR_DP: begin
              next_r.xmem_addr = r.dp16; // [RQ1]
              next_r.xmem_we = op_code[4];
              next_r.xmem_wdata = r.acc; // [RQ2]
              next_r.xmem_req = 1'b1;
              next_r.op_done = 1'b0;
              next_r.st = mcbt_pkg::MCBT_XMEM;
            end
            mcbt_pkg::OP_XMEM_RD_R0, mcbt_pkg::OP_XMEM_RD_R1,
            mcbt_pkg::OP_XMEM_WR_R0, mcbt_pkg::OP_XMEM_WR_R1: begin
              reg_a = ptr_addr(r.stat, op_code[0]);
              next_r.xmem_addr = {8'h00, r.iram[reg_a[6:0]]}; // [RQ1]
              next_r.xmem_we = op_code[4];
              next_r.xmem_wdata = r.acc; // [RQ2]
              next_r.xmem_req = 1'b1;
              next_r.op_done = 1'b0;
              next_r.st = mcbt_pkg::MCBT_XMEM;
            end
            mcbt_pkg::OP_CODE_DP: begin
              // Read-only request, no write strobe on this port [RQ5]
              next_r.cmem_addr = r.dp16 + {8'h00, r.acc}; // [RQ3] [RQ19]
              next_r.cmem_req = 1'b1;
              next_r.op_done = 1'b0;
              next_r.st = mcbt_pkg::MCBT_CMEM;
            end
            mcbt_pkg::OP_CODE_PC: begin
              next_r.cmem_addr = pc_next + {8'h00, r.acc}; // [RQ4] [RQ19]
              next_r.cmem_req = 1'b1;
              next_r.op_done = 1'b0;
              next_r.st = mcbt_pkg::MCBT_CMEM;
            end
            mcbt_pkg::OP_AND_C_BIT: next_r.stat[mcbt_pkg::CARRY_POS] = carry & bit_val; // [RQ10]
            mcbt_pkg::OP_AND_C_NBIT: next_r.stat[mcbt_pkg::CARRY_POS] = carry & ~bit_val; // [RQ10]
            mcbt_pkg::OP_OR_C_BIT: next_r.stat[mcbt_pkg::CARRY_POS] = carry | bit_val; // [RQ10]
            mcbt_pkg::OP_OR_C_NBIT: next_r.stat[mcbt_pkg::CARRY_POS] = carry | ~bit_val; // [RQ10]
            mcbt_pkg::OP_MOV_C_BIT: next_r.stat[mcbt_pkg::CARRY_POS] = bit_val; // [RQ10]
            mcbt_pkg::OP_MOV_BIT_C: begin
              // Only the addressed line of a port latch changes [RQ8] [RQ10]
              latch_byte[bit_pos] = carry;
              next_r = wr_byte(next_r, bit_byte, latch_byte);
            end
            mcbt_pkg::OP_CLR_C: next_r.stat[mcbt_pkg::CARRY_POS] = 1'b0; // [RQ12]
            mcbt_pkg::OP_SET_C: next_r.stat[mcbt_pkg::CARRY_POS] = 1'b1; // [RQ12]
            mcbt_pkg::OP_INV_C: next_r.stat[mcbt_pkg::CARRY_POS] = ~carry; // [RQ12]
            mcbt_pkg::OP_CLR_BIT: begin
              latch_byte[bit_pos] = 1'b0; // [RQ10]
              next_r = wr_byte(next_r, bit_byte, latch_byte);
            end
            mcbt_pkg::OP_SET_BIT: begin
              latch_byte[bit_pos] = 1'b1; // [RQ10]
              next_r = wr_byte(next_r, bit_byte, latch_byte);
            end
            mcbt_pkg::OP_INV_BIT: begin
              latch_byte[bit_pos] = ~bit_latch; // [RQ10]
              next_r = wr_byte(next_r, bit_byte, latch_byte);
            end
            mcbt_pkg::OP_JMP_C_SET: begin
              next_r.branch_taken = carry; // [RQ14]
              next_r.branch_target = rel_target(pc_next, op_byte1);
            end
            mcbt_pkg::OP_JMP_C_CLR: begin
              next_r.branch_taken = ~carry; // [RQ14]
              next_r.branch_target = rel_target(pc_next, op_byte1);
            end
            mcbt_pkg::OP_JMP_B_SET: next_r.branch_taken = bit_val; // [RQ14] [RQ16]
            mcbt_pkg::OP_JMP_B_CLR: next_r.branch_taken = ~bit_val; // [RQ14] [RQ16]
            mcbt_pkg::OP_JMP_B_SETCLR: begin
              // Test on the latch so a port flag is cleared exactly as seen
              next_r.branch_taken = bit_latch; // [RQ14]
              if (bit_latch) begin
                latch_byte[bit_pos] = 1'b0; // [RQ15]
                next_r = wr_byte(next_r, bit_byte, latch_byte);
              end
            end
            mcbt_pkg::OP_EXCH_DIR: begin
              mem_val = rd_byte(r, op_byte1, 1'b1);
              next_r = wr_byte(next_r, op_byte1, r.acc); // [RQ17]
              next_r.acc = mem_val;
            end
            mcbt_pkg::OP_EXCH_IND0, mcbt_pkg::OP_EXCH_IND1: begin
              reg_a = r.iram[ptr_addr(r.stat, op_code[0])];
              mem_val = r.iram[reg_a[6:0]];
              next_r.iram[reg_a[6:0]] = r.acc; // [RQ17]
              next_r.acc = mem_val;
            end
            mcbt_pkg::OP_NEXCH_IND0, mcbt_pkg::OP_NEXCH_IND1: begin
              reg_a = r.iram[ptr_addr(r.stat, op_code[0])];
              mem_val = r.iram[reg_a[6:0]];
              next_r.iram[reg_a[6:0]] = {mem_val[7:4], r.acc[3:0]}; // [RQ18]
              next_r.acc = {r.acc[7:4], mem_val[3:0]}; // [RQ18]
            end
            mcbt_pkg::OP_MOV_A_IMM: next_r.acc = op_byte1;
            mcbt_pkg::OP_MOV_DP_IMM: next_r.dp16 = {op_byte1, op_byte2};
            default: begin
              if (op_code[7:3] == mcbt_pkg::OP_EXCH_REG_HI) begin
                reg_a = {3'b000, r.stat[mcbt_pkg::BANK_LO_POS+1 -: 2], op_code[2:0]};
                next_r.iram[reg_a[6:0]] = r.acc; // [RQ17]
                next_r.acc = r.iram[reg_a[6:0]];
              end else begin
                // No bit exclusive-OR, nor anything else outside this set [RQ13]
                next_r.illegal_op = 1'b1;
              end
            end
          endcase
        end
      end
      mcbt_pkg::MCBT_XMEM: begin
        if (xmem_ack) begin
          if (!r.xmem_we) begin
            next_r.acc = xmem_rdata; // [RQ2]
          end
          next_r.xmem_req = 1'b0;
          next_r.xmem_we = 1'b0;
          next_r.op_done = 1'b1;
          next_r.st = mcbt_pkg::MCBT_IDLE;
        end
      end
      mcbt_pkg::MCBT_CMEM: begin
        if (cmem_ack) begin
          next_r.acc = cmem_rdata; // [RQ3]
          next_r.cmem_req = 1'b0;
          next_r.op_done = 1'b1;
          next_r.st = mcbt_pkg::MCBT_IDLE;
        end
      end
      default: next_r.st = mcbt_pkg::MCBT_IDLE;
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r.st <= mcbt_pkg::MCBT_IDLE;
      r.acc <= mcbt_pkg::RST_ACC;
      r.breg <= mcbt_pkg::RST_BREG;
      r.stat <= mcbt_pkg::RST_STATUS;
      r.dp16 <= mcbt_pkg::RST_DP16;
      r.port <= {4{mcbt_pkg::RST_PORT}};
      r.iram <= {mcbt_pkg::IRAM_DEPTH{mcbt_pkg::RST_IRAM}};
      r.pin_s1 <= 32'h00000000;
      r.pin_s2 <= 32'h00000000;
      r.xmem_req <= 1'b0;
      r.xmem_we <= 1'b0;
      r.xmem_addr <= 16'h0000;
      r.xmem_wdata <= 8'h00;
      r.cmem_req <= 1'b0;
      r.cmem_addr <= 16'h0000;
      r.op_done <= 1'b0;
      r.branch_taken <= 1'b0;
      r.branch_target <= 16'h0000;
      r.illegal_op <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign op_ready = (r.st == mcbt_pkg::MCBT_IDLE);
  assign op_done = r.op_done;
  assign illegal_op = r.illegal_op;
  assign branch_taken = r.branch_taken;
  assign branch_target = r.branch_target;
  assign xmem_req = r.xmem_req;
  assign xmem_we = r.xmem_we;
  assign xmem_addr = r.xmem_addr;
  assign xmem_wdata = r.xmem_wdata;
  assign cmem_req = r.cmem_req;
  assign cmem_addr = r.cmem_addr;
  assign port_latch_out = r.port;
  assign acc_out = r.acc;
  assign status_word_out = stat_view(r);
  assign data_pointer16_out = r.dp16;

endmodule : mcbt_exec

// *** mcbt_pkg.sv ***
// Constants shared by the bit and table executor and its bit address decoder.
// Assumes a single 125 MHz clock domain; memories answer with a one-cycle ack.
package mcbt_pkg;

  // ==========================================================================
  // Opcodes handled by the executor
  // ==========================================================================
  localparam logic [7:0] OP_XMEM_RD_DP = 8'hE0;
  localparam logic [7:0] OP_XMEM_RD_R0 = 8'hE2;
  localparam logic [7:0] OP_XMEM_RD_R1 = 8'hE3;
  localparam logic [7:0] OP_XMEM_WR_DP = 8'hF0;
  localparam logic [7:0] OP_XMEM_WR_R0 = 8'hF2;
  localparam logic [7:0] OP_XMEM_WR_R1 = 8'hF3;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_C_BIT = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_INV_C = 8'hB3;
  localparam logic [7:0] OP_INV_BIT = 8'hB2;
  localparam logic [7:0] OP_JMP_C_SET = 8'h40;
  localparam logic [7:0] OP_JMP_C_CLR = 8'h50;
  localparam logic [7:0] OP_JMP_B_SET = 8'h20;
  localparam logic [7:0] OP_JMP_B_CLR = 8'h30;
  localparam logic [7:0] OP_JMP_B_SETCLR = 8'h10;
  localparam logic [7:0] OP_EXCH_DIR = 8'hC5;
  localparam logic [7:0] OP_EXCH_IND0 = 8'hC6;
  localparam logic [7:0] OP_EXCH_IND1 = 8'hC7;
  localparam logic [4:0] OP_EXCH_REG_HI = 5'h19;
  localparam logic [7:0] OP_NEXCH_IND0 = 8'hD6;
  localparam logic [7:0] OP_NEXCH_IND1 = 8'hD7;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_DP_IMM = 8'h90;

  // ==========================================================================
  // Special function register byte addresses
  // ==========================================================================
  localparam logic [7:0] REG_PORT0 = 8'h80;
  localparam logic [7:0] REG_DP_LO = 8'h82;
  localparam logic [7:0] REG_DP_HI = 8'h83;
  localparam logic [7:0] REG_PORT1 = 8'h90;
  localparam logic [7:0] REG_PORT2 = 8'hA0;
  localparam logic [7:0] REG_PORT3 = 8'hB0;
  localparam logic [7:0] REG_STATUS = 8'hD0;
  localparam logic [7:0] REG_ACC = 8'hE0;
  localparam logic [7:0] REG_BREG = 8'hF0;

  // ==========================================================================
  // Bit map, field positions and reset values
  // ==========================================================================
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam int CARRY_POS = 7;
  localparam int BANK_LO_POS = 3;
  localparam int IRAM_DEPTH = 128;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_BREG = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [15:0] RST_DP16 = 16'h0000;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_IRAM = 8'h00;

  typedef enum logic [1:0] {
    MCBT_IDLE,
    MCBT_XMEM,
    MCBT_CMEM
  } mcbt_state_t;

  typedef struct packed {
    mcbt_state_t st;
    logic [7:0] acc;
    logic [7:0] breg;
    logic [7:0] stat;
    logic [15:0] dp16;
    logic [3:0][7:0] port;
    logic [IRAM_DEPTH-1:0][7:0] iram;
    logic [31:0] pin_s1;
    logic [31:0] pin_s2;
    logic xmem_req;
    logic xmem_we;
    logic [15:0] xmem_addr;
    logic [7:0] xmem_wdata;
    logic cmem_req;
    logic [15:0] cmem_addr;
    logic op_done;
    logic branch_taken;
    logic [15:0] branch_target;
    logic illegal_op;
  } mcbt_regs_t;

endpackage : mcbt_pkg

// *** mcbt_bit_decode.sv ***
// Bit address decoder: splits an 8-bit direct bit address into byte and bit.
// Purely combinational; used by the executor on the bit operand of each op.
`timescale 1ns/100ps
module mcbt_bit_decode (
  input wire logic [7:0] bit_addr,
  output logic [7:0] byte_addr,
  output logic [2:0] bit_pos,
  output logic in_reg_space
);

  // ==========================================================================
  // Address split
  // ==========================================================================
  always_comb begin
    in_reg_space = bit_addr[7];
    bit_pos = bit_addr[2:0];
    if (bit_addr[7]) begin
      // Upper half: bit-addressable registers sit on 8-byte boundaries
      byte_addr = {bit_addr[7:3], 3'b000};
    end else begin
      // Lower half: 16 bytes of internal RAM from the bit region base
      byte_addr = mcbt_pkg::BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    end
  end

endmodule : mcbt_bit_decode

// *** mcbt_mem_model.sv ***
// Behavioural external data memory and program memory with a settable ack delay.
// Assumes requests are held until ack, one outstanding request per port.
`timescale 1ns/100ps
module mcbt_mem_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] delay,
  input wire logic xmem_req,
  input wire logic xmem_we,
  input wire logic [15:0] xmem_addr,
  input wire logic [7:0] xmem_wdata,
  output logic xmem_ack,
  output logic [7:0] xmem_rdata,
  input wire logic cmem_req,
  input wire logic [15:0] cmem_addr,
  output logic cmem_ack,
  output logic [7:0] cmem_rdata
);
  // ==========================================
  // Memories answer after delay idle cycles
  logic [7:0] xram [0:65535];
  logic [3:0] xn;
  logic [3:0] cn;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {xmem_ack, cmem_ack, xn, cn} <= '0;
      {xmem_rdata, cmem_rdata} <= 16'hA55A;
    end else begin
      xmem_ack <= 1'b0;
      cmem_ack <= 1'b0;
      // Data lines do not keep the last value outside an ack
      xmem_rdata <= ~xmem_rdata;
      cmem_rdata <= ~cmem_rdata;
      if (xmem_req && !xmem_ack) begin
        xn <= xn + 4'h1;
        if (xn == delay) begin
          xn <= 4'h0;
          xmem_ack <= 1'b1;
          if (xmem_we) xram[xmem_addr] <= xmem_wdata;
          else xmem_rdata <= xram[xmem_addr];
        end
      end
      if (cmem_req && !cmem_ack) begin
        cn <= cn + 4'h1;
        if (cn == delay) begin
          cn <= 4'h0;
          cmem_ack <= 1'b1;
          cmem_rdata <= cmem_addr[7:0] ^ cmem_addr[15:8] ^ 8'h3C;
        end
      end
    end
  end
endmodule : mcbt_mem_model

// *** mcbt_exec_chk.sv ***
// Concurrent checks on the executor ports.
// Assumes binding onto mcbt_exec, one clock domain.
`timescale 1ns/100ps
module mcbt_exec_chk (
  input wire logic mclk, rstn, op_valid, op_ready, op_done, branch_taken,
  input wire logic xmem_req, xmem_we, xmem_ack, cmem_req, cmem_ack,
  input wire logic [7:0] op_code, xmem_wdata, xmem_rdata, cmem_rdata,
  input wire logic [7:0] acc_out, status_word_out,
  input wire logic [15:0] pc_next, xmem_addr, cmem_addr, data_pointer16_out
);
  // ==========================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic go = op_valid && op_ready;
  chk_req_hold: assert property (xmem_req && !xmem_ack |=> xmem_req && $stable(xmem_addr))
    else $error("external request changed before ack");
  chk_ri_addr: assert property (go && op_code inside {8'hE2, 8'hE3, 8'hF2, 8'hF3} |=>
    xmem_req && xmem_addr[15:8] == 8'h00) else $error("short pointer address wrong");
  chk_dp_addr: assert property (go && op_code == 8'hE0 |=>
    xmem_req && xmem_addr == data_pointer16_out) else $error("pointer address wrong");
  chk_wr_acc: assert property (xmem_req && xmem_we |-> xmem_wdata == acc_out)
    else $error("write data not accumulator");
  chk_rd_acc: assert property (xmem_req && xmem_ack && !xmem_we |=>
    op_done && acc_out == $past(xmem_rdata)) else $error("read data not in accumulator");
  chk_tbl_dp: assert property (go && op_code == 8'h93 |=> cmem_req &&
    cmem_addr == $past(data_pointer16_out) + {8'h00, $past(acc_out)}) else $error("table addr");
  chk_tbl_pc: assert property (go && op_code == 8'h83 |=> cmem_req &&
    cmem_addr == $past(pc_next) + {8'h00, $past(acc_out)}) else $error("counter table addr");
  chk_tbl_acc: assert property (cmem_req && cmem_ack |=> acc_out == $past(cmem_rdata))
    else $error("table byte not in accumulator");
  chk_jc_take: assert property (go && op_code == 8'h40 |=>
    op_done && branch_taken == $past(status_word_out[7])) else $error("carry jump wrong");
  chk_parity_bit: assert property (status_word_out[0] == ^acc_out)
    else $error("parity flag wrong");
  cover property (xmem_req && xmem_ack && xmem_we);
  cover property (cmem_req && cmem_ack);
  cover property (op_done && branch_taken);
endmodule : mcbt_exec_chk
bind mcbt_exec mcbt_exec_chk u_mcbt_exec_chk (.*);

// *** tb.sv ***
// Self-checking bench for the bit and table executor.
// Assumes the memory model and the checker are compiled first.
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0, rstn = 1'b0, op_valid = 1'b0, dn, il, br;
  logic [7:0] op_code = 8'h00, op_byte1 = 8'h00, op_byte2 = 8'h00;
  logic [15:0] pc_next = 16'h0000;
  logic [3:0] delay = 4'h0;
  logic [31:0] port_pin_in = 32'hFFFFFFFF, port_latch_out;
  logic op_ready, op_done, illegal_op, branch_taken, xmem_req, xmem_we;
  logic xmem_ack, cmem_req, cmem_ack;
  logic [15:0] branch_target, xmem_addr, cmem_addr, data_pointer16_out;
  logic [7:0] xmem_wdata, xmem_rdata, cmem_rdata, acc_out, status_word_out;
  int n_errors = 0, checks = 0;
  mcbt_exec u_mcbt_exec (.*);
  mcbt_mem_model u_mcbt_mem_model (.*);
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) port_pin_in <= port_latch_out;
  // ==========================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic op(input logic [7:0] c, input logic [7:0] b1 = 8'h00,
                    input logic [7:0] b2 = 8'h00, input logic [15:0] pn = 16'h0000);
    int i;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_byte1 <= b1;
    op_byte2 <= b2;
    pc_next <= pn;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      dn = op_done;
      il = illegal_op;
      br = branch_taken;
      if (dn === 1'b1 || il === 1'b1) break;
    end
    if (i == 40) begin
      n_errors++;
      give_verdict();
    end
  endtask : op
  // ==========================================
  // Scenarios
  task automatic t_xmem();
    delay <= 4'h3;
    op(8'h90, 8'h12, 8'h34);
    op(8'h74, 8'hAB);
    op(8'hF0);
    op(8'h74, 8'h00);
    op(8'hE0);
    cmp(8'hAB, acc_out);
    op(8'h74, 8'h40);
    op(8'hC8);
    cmp(8'h00, acc_out);
    op(8'h74, 8'h5C);
    op(8'hF2);
    op(8'h74, 8'h00);
    op(8'hE2);
    cmp(8'h5C, acc_out);
    delay <= 4'h0;
  endtask : t_xmem
  task automatic t_table();
    op(8'h90, 8'h12, 8'hF0);
    op(8'h74, 8'h20);
    op(8'h93);
    cmp(8'h13 ^ 8'h10 ^ 8'h3C, acc_out);
    op(8'h74, 8'h20);
    op(8'h83, 8'h00, 8'h00, 16'h00F0);
    cmp(8'h01 ^ 8'h10 ^ 8'h3C, acc_out);
  endtask : t_table
  task automatic t_bits();
    op(8'hC2, 8'h90);
    cmp(32'hFFFFFEFF, port_latch_out);
    op(8'hD2, 8'h90);
    cmp(32'hFFFFFFFF, port_latch_out);
    op(8'hD3);
    cmp(1'b1, status_word_out[7]);
    op(8'hB3);
    cmp(1'b0, status_word_out[7]);
    op(8'hD2, 8'hD7);
    cmp(1'b1, status_word_out[7]);
    op(8'hC3);
    op(8'hD2, 8'h08);
    op(8'hA2, 8'h08);
    cmp(1'b1, status_word_out[7]);
    op(8'h82, 8'h09);
    cmp(1'b0, status_word_out[7]);
    op(8'h72, 8'h08);
    cmp(1'b1, status_word_out[7]);
    op(8'h92, 8'h7F);
    op(8'hC3);
    op(8'hA2, 8'h7F);
    cmp(1'b1, status_word_out[7]);
    op(8'hB0, 8'h08);
    cmp(1'b0, status_word_out[7]);
    op(8'hA0, 8'h09);
    cmp(1'b1, status_word_out[7]);
    op(8'hB2, 8'h08);
    op(8'hA2, 8'h08);
    cmp(1'b0, status_word_out[7]);
    op(8'hD3);
    op(8'hC2, 8'h90);
    repeat (3) @(posedge mclk);
    op(8'hA2, 8'h90);
    cmp(1'b0, status_word_out[7]);
    op(8'hD2, 8'h90);
    op(8'hA5, 8'h08);
    cmp(1'b1, il);
  endtask : t_bits
  task automatic t_jump();
    op(8'hD3);
    op(8'h40, 8'h05, 8'h00, 16'h0100);
    cmp({1'b1, 16'h0105}, {br, branch_target});
    op(8'h50, 8'h05, 8'h00, 16'h0100);
    cmp(1'b0, br);
    op(8'hD2, 8'h20);
    op(8'h10, 8'h20, 8'h05, 16'h0100);
    cmp({1'b1, 16'h0105}, {br, branch_target});
    op(8'h20, 8'h20, 8'h05, 16'h0100);
    cmp(1'b0, br);
    op(8'h30, 8'h20, 8'hFE, 16'h0100);
    cmp({1'b1, 16'h00FE}, {br, branch_target});
    op(8'h74, 8'h01);
    op(8'h20, 8'hD0, 8'h05, 16'h0100);
    cmp(1'b1, br);
  endtask : t_jump
  task automatic t_xch();
    op(8'h74, 8'h30);
    op(8'hC9);
    op(8'h74, 8'h78);
    op(8'hC5, 8'h30);
    op(8'h74, 8'h56);
    op(8'hD7);
    cmp(8'h58, acc_out);
    op(8'hC5, 8'h30);
    cmp(8'h76, acc_out);
    op(8'hC7);
    cmp(8'h58, acc_out);
    op(8'hF3);
    op(8'h74, 8'h00);
    op(8'hE3);
    cmp(8'h58, acc_out);
  endtask : t_xch
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    cmp(32'h00000000, {acc_out, status_word_out, data_pointer16_out});
    cmp(32'hFFFFFFFF, port_latch_out);
    t_xmem();
    t_table();
    t_bits();
    t_jump();
    t_xch();
    give_verdict();
  end
endmodule : tb
